// ===== hdl/ddrcc_core.v
`timescale 1ns/1ns
`include "ddrcc_defines.vh"
// Contract
// - Decode calibration field into five modes
// - Drive-high: data, strobe high; complement low
// - Drive-low: data, strobe low; complement high
// - Same code all lines; all outputs adjusted
// - Four beats form code; steps pull strengths
// - Strengths saturate within sixteen steps
// - Termination follows control pin when active
// - Termination off throughout self refresh
// - Precharge decode: cs, ras, we low
// - Auto-precharge bit closes all, else one bank
// - Chip select inactive means deselect
// - No-operation; operations in progress continue
// - Activate decode opens bank at row
// - Read decode uses programmed burst and latency
// - Write decode uses programmed burst length
// - Post command by additive latency; write one less
// - Additive latency from address bits three to five
module ddrcc_core #(
  parameter NBANK = 8,
  parameter DQW = 16,
  parameter ROWW = 13
) (
  input wire sys_clk,
  input wire rst_b,
  input wire cs_b,
  input wire ras_b,
  input wire cas_b,
  input wire we_b,
  input wire [2:0] bank_select_bits,
  input wire [ROWW-1:0] addr,
  input wire [DQW-1:0] dq_in,
  input wire self_refresh,
  input wire on_die_termination,
  output reg [DQW-1:0] dq_out,
  output reg [DQW-1:0] dq_oe,
  output reg [1:0] dqs_out,
  output reg [1:0] dqs_b_out,
  output reg [1:0] dqs_oe,
  output reg term_en,
  output reg [NBANK-1:0] bank_open,
  output reg [ROWW*NBANK-1:0] open_rows,
  output reg [2:0] output_driver_calibration,
  output reg [3:0] pullup_step,
  output reg [3:0] pulldown_step,
  output reg [2:0] additive_latency,
  output reg [2:0] column_latency,
  output reg [2:0] burst_len_code,
  output reg cmd_rd,
  output reg cmd_wr,
  output reg [3:0] read_latency,
  output reg [3:0] write_latency,
  output reg [3:0] burst_len,
  output reg [2:0] cmd_bank,
  output reg [ROWW-1:0] cmd_col
);
  localparam S_IDLE = 3'b001;
  localparam S_BEAT = 3'b010;
  localparam S_APPLY = 3'b100;

  // Two-flop synchronisers for all input pins except clock and reset
  reg [3:0] ctl_m_r, ctl_s_r;
  reg [2:0] ba_m_r, ba_s_r;
  reg [ROWW-1:0] a_m_r, a_s_r;
  reg [DQW-1:0] dq_m_r, dq_s_r;
  reg sr_m_r, sr_s_r, odt_m_r, odt_s_r;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_m_r <= 4'hF;
      ctl_s_r <= 4'hF;
      ba_m_r <= 3'h0;
      ba_s_r <= 3'h0;
      a_m_r <= {ROWW{1'b0}};
      a_s_r <= {ROWW{1'b0}};
      dq_m_r <= {DQW{1'b0}};
      dq_s_r <= {DQW{1'b0}};
      sr_m_r <= 1'b0;
      sr_s_r <= 1'b0;
      odt_m_r <= 1'b0;
      odt_s_r <= 1'b0;
    end else begin
      ctl_m_r <= {cs_b, ras_b, cas_b, we_b};
      ctl_s_r <= ctl_m_r;
      ba_m_r <= bank_select_bits;
      ba_s_r <= ba_m_r;
      a_m_r <= addr;
      a_s_r <= a_m_r;
      dq_m_r <= dq_in;
      dq_s_r <= dq_m_r;
      sr_m_r <= self_refresh;
      sr_s_r <= sr_m_r;
      odt_m_r <= on_die_termination;
      odt_s_r <= odt_m_r;
    end
  end

  // Command code match, masked off while deselected
  function is_cmd;
    input en;
    input [2:0] pins;
    input [2:0] code;
    begin
      is_cmd = en & (pins == code);
    end
  endfunction

  // Deselect: chip select high masks every other control input
  wire sel = ~ctl_s_r[3];
  wire dec_mrs = is_cmd(sel, ctl_s_r[2:0], `DDRCC_CMD_MODE);
  wire dec_pre = is_cmd(sel, ctl_s_r[2:0], `DDRCC_CMD_PRE);
  wire dec_act = is_cmd(sel, ctl_s_r[2:0], `DDRCC_CMD_ACT);
  wire dec_rd = is_cmd(sel, ctl_s_r[2:0], `DDRCC_CMD_RD);
  wire dec_wr = is_cmd(sel, ctl_s_r[2:0], `DDRCC_CMD_WR);
  wire set_base = dec_mrs & (ba_s_r == `DDRCC_BA_MODE);
  wire set_ext1 = dec_mrs & (ba_s_r == `DDRCC_BA_EXT1);
  wire [2:0] cal_field = a_s_r[`DDRCC_CAL_MSB:`DDRCC_CAL_LSB];

  function [3:0] sat_step;
    input [3:0] cur;
    input up;
    input dn;
    begin
      if (up && cur != `DDRCC_STEP_MAX) begin
        sat_step = cur + 4'h1;
      end else if (dn && cur != 4'h0) begin
        sat_step = cur - 4'h1;
      end else begin
        sat_step = cur;
      end
    end
  endfunction

  // Four-bit sum: both fields are three bits, so it never wraps
  function [3:0] lat_sum;
    input [2:0] al;
    input [2:0] cl;
    begin
      lat_sum = {1'b0, al} + {1'b0, cl};
    end
  endfunction

  reg [2:0] cal_st_r;
  reg [1:0] beat_r;
  reg [3:0] code_r;
  reg pu_up, pu_dn, pd_up, pd_dn;

  always @* begin
    pu_up = 1'b0;
    pu_dn = 1'b0;
    pd_up = 1'b0;
    pd_dn = 1'b0;
    case (code_r)
      `DDRCC_ADJ_PU_INC: pu_up = 1'b1;
      `DDRCC_ADJ_PU_DEC: pu_dn = 1'b1;
      `DDRCC_ADJ_PD_INC: pd_up = 1'b1;
      `DDRCC_ADJ_PD_DEC: pd_dn = 1'b1;
      `DDRCC_ADJ_UU: begin
        pu_up = 1'b1;
        pd_up = 1'b1;
      end
      `DDRCC_ADJ_DU: begin
        pu_dn = 1'b1;
        pd_up = 1'b1;
      end
      `DDRCC_ADJ_UD: begin
        pu_up = 1'b1;
        pd_dn = 1'b1;
      end
      `DDRCC_ADJ_DD: begin
        pu_dn = 1'b1;
        pd_dn = 1'b1;
      end
      default: pu_up = 1'b0;
    endcase
  end

  // Calibration drive and adjust modes, decoded once
  wire mode_drv_hi = (output_driver_calibration == `DDRCC_CAL_DRV_HI);
  wire mode_drv_lo = (output_driver_calibration == `DDRCC_CAL_DRV_LO);
  wire mode_adj = (output_driver_calibration == `DDRCC_CAL_ADJ);

  // Mode words and calibration
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_driver_calibration <= `DDRCC_CAL_EXIT;
      additive_latency <= `DDRCC_AL_RST;
      column_latency <= `DDRCC_CL_RST;
      burst_len_code <= `DDRCC_BL4;
      pullup_step <= `DDRCC_STEP_DFLT;
      pulldown_step <= `DDRCC_STEP_DFLT;
      cal_st_r <= S_IDLE;
      beat_r <= 2'h0;
      code_r <= `DDRCC_ADJ_NOP;
    end else begin
      if (set_base) begin
        burst_len_code <= a_s_r[`DDRCC_BL_MSB:`DDRCC_BL_LSB];
        column_latency <= a_s_r[`DDRCC_CL_MSB:`DDRCC_CL_LSB];
      end
      if (set_ext1) begin
        additive_latency <= a_s_r[`DDRCC_AL_MSB:`DDRCC_AL_LSB];
        output_driver_calibration <= cal_field;
        if (cal_field == `DDRCC_CAL_DFLT) begin
          pullup_step <= `DDRCC_STEP_DFLT;
          pulldown_step <= `DDRCC_STEP_DFLT;
        end
      end
      case (cal_st_r)
        S_IDLE: begin
          beat_r <= 2'h0;
          // Adjust code is taken as a write burst while adjustable mode is set
          if (dec_wr && mode_adj) begin
            cal_st_r <= S_BEAT;
          end
        end
        S_BEAT: begin
          // Bit time zero lands in the MSB of the code
          code_r <= {code_r[2:0], dq_s_r[0]};
          beat_r <= beat_r + 2'h1;
          if (beat_r == 2'h3) begin
            cal_st_r <= S_APPLY;
          end
        end
        S_APPLY: begin
          // All data outputs share this one pair of step registers
          pullup_step <= sat_step(pullup_step, pu_up, pu_dn);
          pulldown_step <= sat_step(pulldown_step, pd_up, pd_dn);
          cal_st_r <= S_IDLE;
        end
        default: cal_st_r <= S_IDLE;
      endcase
    end
  end

  // Termination follows its pin except in self refresh
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      term_en <= 1'b0;
    end else begin
      term_en <= odt_s_r & ~sr_s_r;
    end
  end

  // Pins under calibration drive modes
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_out <= {DQW{1'b0}};
      dq_oe <= {DQW{1'b0}};
      dqs_out <= 2'h0;
      dqs_b_out <= 2'h0;
      dqs_oe <= 2'h0;
    end else begin
      if (mode_drv_hi) begin
        dq_out <= {DQW{1'b1}};
        dqs_out <= 2'h3;
        dqs_b_out <= 2'h0;
        dq_oe <= {DQW{1'b1}};
        dqs_oe <= 2'h3;
      end else if (mode_drv_lo) begin
        dq_out <= {DQW{1'b0}};
        dqs_out <= 2'h0;
        dqs_b_out <= 2'h3;
        dq_oe <= {DQW{1'b1}};
        dqs_oe <= 2'h3;
      end else begin
        dq_out <= {DQW{1'b0}};
        dqs_out <= 2'h0;
        dqs_b_out <= 2'h0;
        dq_oe <= {DQW{1'b0}};
        dqs_oe <= 2'h0;
      end
    end
  end

  // Bank state; idle and deselect cycles leave it untouched
  integer b;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_open <= {NBANK{1'b0}};
      open_rows <= {ROWW*NBANK{1'b0}};
    end else begin
      for (b = 0; b < NBANK; b = b + 1) begin
        if (dec_pre && (a_s_r[`DDRCC_AP_BIT] || ba_s_r == b[2:0])) begin
          bank_open[b] <= 1'b0;
        end else if (dec_act && ba_s_r == b[2:0]) begin
          bank_open[b] <= 1'b1;
          open_rows[b*ROWW +: ROWW] <= a_s_r;
        end
      end
    end
  end

  // Posted column commands
  // One delay line keeps reads and writes in issue order
  wire post_vld, post_wr;
  wire [ROWW+2:0] post_addr;
  ddrcc_post_delay #(
    .DEPTH(8),
    .AW(ROWW + 3)
  ) u_post (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .delay(additive_latency),
    .in_vld(dec_rd | dec_wr),
    .in_wr(dec_wr),
    .in_addr({ba_s_r, a_s_r}),
    .out_vld(post_vld),
    .out_wr(post_wr),
    .out_addr(post_addr)
  );

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_rd <= 1'b0;
      cmd_wr <= 1'b0;
      cmd_bank <= 3'h0;
      cmd_col <= {ROWW{1'b0}};
      read_latency <= 4'h0;
      write_latency <= 4'h0;
      burst_len <= `DDRCC_BURST_SHORT;
    end else begin
      cmd_rd <= post_vld & ~post_wr;
      cmd_wr <= post_vld & post_wr;
      if (post_vld) begin
        cmd_bank <= post_addr[ROWW+2:ROWW];
        cmd_col <= post_addr[ROWW-1:0];
      end
      read_latency <= lat_sum(additive_latency, column_latency);
      write_latency <= lat_sum(additive_latency, column_latency) - 4'h1;
      burst_len <= (burst_len_code == `DDRCC_BL8) ? `DDRCC_BURST_LONG : `DDRCC_BURST_SHORT;
    end
  end
endmodule

// ===== hdl/ddrcc_defines.vh
`ifndef DDRCC_DEFINES_VH
`define DDRCC_DEFINES_VH
`define DDRCC_CAL_LSB 7
`define DDRCC_CAL_MSB 9
`define DDRCC_CAL_EXIT 3'h0
`define DDRCC_CAL_DRV_HI 3'h1
`define DDRCC_CAL_DRV_LO 3'h2
`define DDRCC_CAL_ADJ 3'h4
`define DDRCC_CAL_DFLT 3'h7
`define DDRCC_AL_LSB 3
`define DDRCC_AL_MSB 5
`define DDRCC_BL_LSB 0
`define DDRCC_BL_MSB 2
`define DDRCC_BL4 3'h2
`define DDRCC_BL8 3'h3
`define DDRCC_CL_LSB 4
`define DDRCC_CL_MSB 6
`define DDRCC_AP_BIT 10
`define DDRCC_BA_MODE 3'h0
`define DDRCC_BA_EXT1 3'h1
`define DDRCC_ADJ_NOP 4'h0
`define DDRCC_ADJ_PU_INC 4'h1
`define DDRCC_ADJ_PU_DEC 4'h2
`define DDRCC_ADJ_PD_INC 4'h4
`define DDRCC_ADJ_PD_DEC 4'h8
`define DDRCC_ADJ_UU 4'h5
`define DDRCC_ADJ_DU 4'h6
`define DDRCC_ADJ_UD 4'h9
`define DDRCC_ADJ_DD 4'hA
`define DDRCC_STEP_MAX 4'hF
`define DDRCC_STEP_DFLT 4'h8
`define DDRCC_CMD_MODE 3'h0
`define DDRCC_CMD_PRE 3'h2
`define DDRCC_CMD_ACT 3'h3
`define DDRCC_CMD_WR 3'h4
`define DDRCC_CMD_RD 3'h5
`define DDRCC_AL_RST 3'h0
`define DDRCC_CL_RST 3'h3
`define DDRCC_BURST_SHORT 4'h4
`define DDRCC_BURST_LONG 4'h8
`endif

// ===== hdl/ddrcc_post_delay.v
`timescale 1ns/1ns
// Holds a read or write command for a programmable number of cycles
module ddrcc_post_delay #(
  parameter DEPTH = 8,
  parameter AW = 14
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [2:0] delay,
  input wire in_vld,
  input wire in_wr,
  input wire [AW-1:0] in_addr,
  output reg out_vld,
  output reg out_wr,
  output reg [AW-1:0] out_addr
);
  reg [DEPTH-1:0] vld_r;
  reg [DEPTH-1:0] wr_r;
  reg [AW-1:0] addr_r [0:DEPTH-1];
  integer i;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vld_r <= {DEPTH{1'b0}};
      wr_r <= {DEPTH{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        addr_r[i] <= {AW{1'b0}};
      end
    end else begin
      vld_r <= {vld_r[DEPTH-2:0], in_vld};
      wr_r <= {wr_r[DEPTH-2:0], in_wr};
      addr_r[0] <= in_addr;
      for (i = 1; i < DEPTH; i = i + 1) begin
        addr_r[i] <= addr_r[i-1];
      end
    end
  end

  // Delay 0 passes straight through; delay n picks stage n-1
  always @* begin
    if (delay == 3'h0) begin
      out_vld = in_vld;
      out_wr = in_wr;
      out_addr = in_addr;
    end else begin
      out_vld = vld_r[delay - 3'h1];
      out_wr = wr_r[delay - 3'h1];
      out_addr = addr_r[delay - 3'h1];
    end
  end
endmodule

// ===== tb/ddrcc_core_monitor.sv
`timescale 1ns/1ns
module ddrcc_core_monitor #(
  parameter NBANK = 8,
  parameter DQW = 16,
  parameter ROWW = 13
) (
  input wire sys_clk,
  input wire rst_b,
  input wire cs_b,
  input wire ras_b,
  input wire cas_b,
  input wire we_b,
  input wire [2:0] bank_select_bits,
  input wire [ROWW-1:0] addr,
  input wire self_refresh,
  input wire on_die_termination,
  input wire [DQW-1:0] dq_out,
  input wire [DQW-1:0] dq_oe,
  input wire [1:0] dqs_out,
  input wire [1:0] dqs_b_out,
  input wire [1:0] dqs_oe,
  input wire term_en,
  input wire [NBANK-1:0] bank_open,
  input wire [ROWW*NBANK-1:0] open_rows,
  input wire [2:0] output_driver_calibration,
  input wire [2:0] additive_latency,
  input wire [2:0] column_latency,
  input wire [3:0] read_latency,
  input wire [3:0] write_latency
);
  wire pre_cmd = !cs_b && !ras_b && cas_b && !we_b;
  wire act_cmd = !cs_b && !ras_b && cas_b && we_b;
  wire ext_cmd = !cs_b && !ras_b && !cas_b && !we_b && bank_select_bits == 3'h1;
  wire [2:0] cal_pin = addr[9:7];
  wire [2:0] al_pin = addr[5:3];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_mode_decode:
    assert property (ext_cmd |-> ##3 output_driver_calibration == $past(cal_pin, 3)
      && additive_latency == $past(al_pin, 3)) else $error("mode word decode");
  chk_drive_high:
    assert property ((output_driver_calibration == 3'h1)[*2] |-> &dq_out && &dq_oe
      && dqs_out == 2'h3 && dqs_b_out == 2'h0 && &dqs_oe) else $error("drive high levels");
  chk_drive_low:
    assert property ((output_driver_calibration == 3'h2)[*2] |-> !(|dq_out) && &dq_oe
      && dqs_out == 2'h0 && dqs_b_out == 2'h3 && &dqs_oe) else $error("drive low levels");
  chk_term_on:
    assert property ((on_die_termination && !self_refresh)[*5] |-> term_en) else $error("termination off");
  chk_term_off:
    assert property ((self_refresh || !on_die_termination)[*5] |-> !term_en) else $error("termination on");
  chk_pre_all:
    assert property (pre_cmd && addr[10] |-> ##3 bank_open == {NBANK{1'b0}}) else $error("precharge all");
  chk_pre_one:
    assert property (pre_cmd && !addr[10] |-> ##3 !bank_open[$past(bank_select_bits, 3)])
      else $error("precharge one bank");
  chk_act_open:
    assert property (act_cmd |-> ##3 bank_open[$past(bank_select_bits, 3)]
      && open_rows[$past(bank_select_bits, 3)*ROWW +: ROWW] == $past(addr, 3)) else $error("activate");
  chk_desel_hold:
    assert property (cs_b |-> ##3 $stable(bank_open) && $stable(additive_latency)
      && $stable(output_driver_calibration)) else $error("deselect changed state");
  chk_lat_sum:
    assert property (($stable(additive_latency) && $stable(column_latency))[*3] |->
      read_latency == additive_latency + column_latency && write_latency == read_latency - 4'h1)
      else $error("latency sums");
  cover property (act_cmd);
  cover property (pre_cmd && addr[10]);
  cover property (output_driver_calibration == 3'h4);
endmodule

bind ddrcc_core ddrcc_core_monitor #(.NBANK(NBANK), .DQW(DQW), .ROWW(ROWW)) u_mon (
  .sys_clk, .rst_b, .cs_b, .ras_b, .cas_b, .we_b, .bank_select_bits, .addr, .self_refresh,
  .on_die_termination, .dq_out, .dq_oe, .dqs_out, .dqs_b_out, .dqs_oe, .term_en, .bank_open,
  .open_rows, .output_driver_calibration, .additive_latency, .column_latency, .read_latency,
  .write_latency);

// ===== tb/ddrcc_ctl_model.sv
`timescale 1ns/1ns
module ddrcc_ctl_model (
  input wire sys_clk,
  output reg cs_b,
  output reg ras_b,
  output reg cas_b,
  output reg we_b,
  output reg [2:0] bank_select_bits,
  output reg [12:0] addr,
  output reg [15:0] dq_in
);
  initial begin
    {cs_b, ras_b, cas_b, we_b} = 4'hF;
    bank_select_bits = 3'h0;
    addr = 13'h0000;
    dq_in = 16'h0000;
  end
  // One command cycle, then no-operation; gap sets how slowly the next follows
  task cmd(input [3:0] c, input [2:0] ba, input [12:0] a, input integer gap);
    begin
      @(posedge sys_clk) #1;
      {cs_b, ras_b, cas_b, we_b} = c;
      bank_select_bits = ba;
      addr = a;
      @(posedge sys_clk) #1;
      {cs_b, ras_b, cas_b, we_b} = 4'h7;
      addr = ~a;
      repeat (gap) @(posedge sys_clk) #1;
    end
  endtask
  // Write opens the code burst; first beat is bit time zero
  task adjust(input [3:0] code);
    integer i;
    begin
      @(posedge sys_clk) #1;
      {cs_b, ras_b, cas_b, we_b} = 4'h4;
      for (i = 3; i >= 0; i = i - 1) begin
        @(posedge sys_clk) #1;
        {cs_b, ras_b, cas_b, we_b} = 4'h7;
        dq_in = {16{code[i]}};
      end
      @(posedge sys_clk) #1;
      dq_in = ~dq_in;
    end
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  reg sys_clk, rst_b, self_refresh, on_die_termination;
  wire cs_b, ras_b, cas_b, we_b, term_en, cmd_rd, cmd_wr;
  wire [2:0] bank_select_bits, output_driver_calibration, additive_latency, column_latency, burst_len_code, cmd_bank;
  wire [12:0] addr, cmd_col;
  wire [15:0] dq_in, dq_out, dq_oe;
  wire [1:0] dqs_out, dqs_b_out, dqs_oe;
  wire [7:0] bank_open;
  wire [103:0] open_rows;
  wire [3:0] pullup_step, pulldown_step, read_latency, write_latency, burst_len;
  integer error_cnt, tests_run, k, n;
  // Adjust code, then expected pull-up and pull-down steps
  logic [0:10][11:0] rows = {12'h198, 12'h288, 12'h489, 12'h888, 12'h599, 12'h68A, 12'h999, 12'hA88,
    12'h088, 12'h388, 12'hF88};
  ddrcc_ctl_model ctl (.sys_clk, .cs_b, .ras_b, .cas_b, .we_b, .bank_select_bits, .addr, .dq_in);
  ddrcc_core DUT (.sys_clk, .rst_b, .cs_b, .ras_b, .cas_b, .we_b, .bank_select_bits, .addr, .dq_in,
    .self_refresh, .on_die_termination, .dq_out, .dq_oe, .dqs_out, .dqs_b_out, .dqs_oe, .term_en,
    .bank_open, .open_rows, .output_driver_calibration, .pullup_step, .pulldown_step, .additive_latency,
    .column_latency, .burst_len_code, .cmd_rd, .cmd_wr, .read_latency, .write_latency, .burst_len,
    .cmd_bank, .cmd_col);
  task chk(input string nm, input [47:0] e, input [47:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (error_cnt == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task emrs(input [12:0] a);
    ctl.cmd(4'h0, 3'h1, a, 3);
  endtask
  task adj(input [3:0] code);
    begin
      emrs(13'h0210);
      ctl.adjust(code);
      emrs(13'h0010);
    end
  endtask
  task pulse(input rd, input integer exp);
    begin
      n = 0;
      while (n < 20 && (rd ? cmd_rd : cmd_wr) !== 1'b1) begin
        @(posedge sys_clk) #1;
        n = n + 1;
      end
      chk("post_delay", exp, n);
      if (n == 20) report_and_stop;
      @(posedge sys_clk) #1;
      chk("pulse_end", 0, {cmd_rd, cmd_wr});
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst_b = 1'b0;
    self_refresh = 1'b0;
    on_die_termination = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    chk("reset", 20'h43288,
      {burst_len, 1'b0, column_latency, 1'b0, burst_len_code, pullup_step, pulldown_step});
    ctl.cmd(4'h0, 3'h0, 13'h0053, 3);
    chk("burst_len", 4'h8, burst_len);
    ctl.cmd(4'h0, 3'h0, 13'h0052, 3);
    emrs(13'h0010);
    chk("latency", 16'h2576, {additive_latency, 1'b0, column_latency, read_latency, write_latency});
    ctl.cmd(4'h3, 3'h3, 13'h1ABC, 3);
    chk("open_row", 24'h081ABC, {bank_open, 3'h0, open_rows[39+:13]});
    ctl.cmd(4'h5, 3'h3, 13'h0004, 0);
    pulse(1, 4);
    chk("cmd_bank", 3'h3, cmd_bank);
    chk("cmd_col", 13'h0004, cmd_col);
    chk("bank_open", 8'h08, bank_open);
    ctl.cmd(4'h4, 3'h3, 13'h0008, 0);
    pulse(0, 4);
    chk("cmd_col", 13'h0008, cmd_col);
    ctl.cmd(4'h3, 3'h5, 13'h0123, 3);
    ctl.cmd(4'h2, 3'h3, 13'h0000, 3);
    chk("bank_open", 8'h20, bank_open);
    ctl.cmd(4'hB, 3'h1, 13'h0000, 3);
    chk("bank_open", 8'h20, bank_open);
    ctl.cmd(4'h2, 3'h0, 13'h0400, 3);
    chk("bank_open", 8'h00, bank_open);
    emrs(13'h0090);
    chk("drive", 48'h3FFFFFFFF3, {dq_out, dq_oe, dqs_out, dqs_b_out, dqs_oe});
    emrs(13'h0110);
    chk("drive", 48'h3FFFCF, {dq_out, dq_oe, dqs_out, dqs_b_out, dqs_oe});
    emrs(13'h0010);
    for (k = 0; k < 4; k = k + 1) begin
      {self_refresh, on_die_termination} = k[1:0];
      repeat (6) @(posedge sys_clk) #1;
      chk("term_en", k == 1, term_en);
    end
    {self_refresh, on_die_termination} = 2'h0;
    for (k = 0; k < 11; k = k + 1) begin
      adj(rows[k][11:8]);
      chk("steps", rows[k][7:0], {pullup_step, pulldown_step});
    end
    repeat (9) adj(4'h5);
    chk("steps", 8'hFF, {pullup_step, pulldown_step});
    emrs(13'h0390);
    chk("steps", 8'h88, {pullup_step, pulldown_step});
    emrs(13'h0010);
    repeat (9) adj(4'hA);
    chk("steps", 8'h00, {pullup_step, pulldown_step});
    chk("additive_latency", 3'h2, additive_latency);
    report_and_stop;
  end
endmodule
